//--- mpb_param_bank.sv
// Motion profile and scaling parameter bank with fieldbus parameter access
// Contract
// - Direction 0 clockwise, 1 counter-clockwise
// - Direction write only disabled, active after power-on
// - Denominator 1..2147483647, default 16384
// - Numerator 1..2147483647, default 1
// - Denominator activates only when numerator written
// - Scaling writes rejected while power stage enabled
// - Position velocity 1..13200, clamped to maxima
// - Velocity target +-13200, clamped, immediate
// - Absolute target within limits, takes effect immediately
// - Motor-referenced relative adds to motor position
// - Target-referenced relative adds to running target
// - Standstill relative move may overrun, zeroes position
// - Jerk 0 or 1..128 ms powers of two
// - Jerk change only when motion finished
// - Acceleration 1..3000000, default 600
// - Deceleration 750..3000000, default 750
// - Ramp changes apply at next motion start
// - Packed word: acc high, dec low, times ten
// - Packed write updates both, each limit checked
// - Packed readback halves saturate to 65535
`timescale 1ns/1ps
module mpb_param_bank
	import mpb_pkg::*;
(
	input  wire logic        ref_clk_in,          // 125 MHz motion clock
	input  wire logic        nrst_in,             // Asynchronous reset, active low
	input  wire logic        req_valid_in,        // Parameter request strobe
	input  wire mpb_req_t    req_in,              // Parameter request
	input  wire logic        power_stage_en_in,   // Power stage enabled
	input  wire logic        power_on_in,         // Power-on event pulse
	input  wire logic        motion_finished_in,  // Operating mode inactive
	input  wire logic        motion_start_in,     // Pulse at start of a movement
	input  wire logic [31:0] motor_position_in,   // Actual position, user units
	input  wire logic [31:0] pos_limit_min_in,    // Lower user position limit
	input  wire logic [31:0] pos_limit_max_in,    // Upper user position limit
	input  wire logic [15:0] max_profile_velocity_in, // Maximum profile velocity
	input  wire logic [15:0] max_speed_in,        // Maximum speed
	output mpb_rsp_t         rsp_out,             // Answer to master
	output mpb_target_t      target_out,          // New target towards controller
	output logic             active_direction_out, // Direction in force
	output logic [31:0]      active_scale_num_out, // Scaling numerator in force
	output logic [31:0]      active_scale_den_out, // Scaling denominator in force
	output logic [31:0]      active_acc_out,      // Acceleration of current motion
	output logic [31:0]      active_dec_out,      // Deceleration of current motion
	output logic [7:0]       active_jerk_out,     // Jerk time of current motion
	output logic [15:0]      pp_velocity_out,     // Clamped position mode velocity
	output logic [31:0]      pv_velocity_out      // Clamped velocity mode target
);

	// Settings in flip-flops; active copies feed the motion path
	// Stored settings as seen by the master
	logic        rotation_direction;            // Pending direction
	logic [31:0] scale_denominator;             // Written denominator, not yet active
	logic [31:0] scale_numerator;               // Written numerator
	logic [31:0] profile_acceleration;          // Next-motion acceleration
	logic [31:0] profile_deceleration;          // Next-motion deceleration
	logic [7:0]  jerk_filter_time;              // Next-motion jerk time
	logic [15:0] position_mode_target_velocity; // Unclamped request
	logic [31:0] velocity_mode_target;          // Unclamped request
	logic [31:0] absolute_target_position;      // Last absolute write
	logic [31:0] relative_to_motor_target;      // Last motor-referenced write
	logic [31:0] relative_to_target_target;     // Last target-referenced write
	logic [31:0] current_target;                // Target of the movement in progress

	// A request is a one-cycle strobe, so no holding register
	// Write bit alone tells reads from writes
	// Decoded access
	logic        wr;
	logic        rd;
	logic [31:0] wv;
	assign wr = req_valid_in & req_in.write;
	assign rd = req_valid_in & ~req_in.write;
	assign wv = req_in.wdata;

	// All range checks run at once; the address decode picks one
	// Helper checks
	logic        scale_ok;     // Value within scaling range
	logic        vel_ok;       // Unsigned velocity within range
	logic        pv_ok;        // Signed velocity within range
	logic        acc_ok;
	logic        dec_ok;
	logic        jerk_ok;
	logic [31:0] pack_acc;     // Upper half times ten
	logic [31:0] pack_dec;     // Lower half times ten
	logic        pack_ok;
	logic [31:0] pv_mag;       // Magnitude of the written velocity
	logic [32:0] rel_motor_sum;
	logic [32:0] rel_target_sum;
	logic        abs_in_limits;
	logic        relm_in_limits;
	logic        relt_in_limits;

	assign scale_ok = ($signed(wv) >= $signed(SCALE_MIN)) && ($signed(wv) <= $signed(SCALE_MAX));
	assign vel_ok   = (wv[31:16] == 16'h0000) && (wv[15:0] >= VEL_MIN) && (wv[15:0] <= VEL_MAX);
	assign pv_mag   = wv[31] ? (32'h0000_0000 - wv) : wv;
	assign pv_ok    = (pv_mag <= {16'h0000, VEL_MAX});
	assign acc_ok   = (wv >= ACC_MIN) && (wv <= RAMP_MAX);
	assign dec_ok   = (wv >= DEC_MIN) && (wv <= RAMP_MAX);
	// Mask plus power-of-two test; 256 and up are refused
	// Zero, or a single set bit among 1..128 ms
	assign jerk_ok  = (wv[31:16] == 16'h0000) && ((wv[15:0] & ~JERK_ALLOWED_MASK) == 16'h0000)
	                  && ((wv[15:0] & (wv[15:0] - 16'h0001)) == 16'h0000);
	// Each half scaled by ten; a 16-bit half times ten always fits in 32 bits
	assign pack_acc = 32'(wv[PACK_ACC_LSB +: 16]) * PACK_SCALE;
	assign pack_dec = 32'(wv[PACK_DEC_LSB +: 16]) * PACK_SCALE;
	assign pack_ok  = (pack_acc >= ACC_MIN) && (pack_acc <= RAMP_MAX)
	                  && (pack_dec >= DEC_MIN) && (pack_dec <= RAMP_MAX);

	// Relative sums against motor position or running target
	// Sums kept one bit wider so a wrap cannot sneak past the limit check
	assign rel_motor_sum  = {motor_position_in[31], motor_position_in} + {wv[31], wv};
	assign rel_target_sum = {current_target[31], current_target} + {wv[31], wv};

	// Unsigned compares would let a negative target look huge
	// Limit checks in signed arithmetic
	function automatic logic in_limits(input logic [32:0] v, input logic [31:0] lo, input logic [31:0] hi);
		in_limits = ($signed(v) >= $signed({lo[31], lo})) && ($signed(v) <= $signed({hi[31], hi}));
	endfunction
	assign abs_in_limits  = in_limits({wv[31], wv}, pos_limit_min_in, pos_limit_max_in);
	assign relm_in_limits = in_limits(rel_motor_sum, pos_limit_min_in, pos_limit_max_in);
	assign relt_in_limits = in_limits(rel_target_sum, pos_limit_min_in, pos_limit_max_in);

	// Locks follow drive state in the request cycle; a refused
	// write is reported and never half applied
	// Write acceptance per address; a refused write changes nothing
	// Accept defaults low so an odd address is never taken
	logic accept;
	logic mapped;
	always_comb begin
		accept = 1'b0;
		mapped = 1'b1;
		case (req_in.addr)
			ADDR_SCALE_DEN:   accept = scale_ok & ~power_stage_en_in;
			ADDR_SCALE_NUM:   accept = scale_ok & ~power_stage_en_in;
			ADDR_PROF_ACC:    accept = acc_ok;
			ADDR_PROF_DEC:    accept = dec_ok;
			ADDR_ROT_DIR:     accept = (wv[31:1] == 31'h0) & ~power_stage_en_in;
			ADDR_JERK:        accept = jerk_ok & motion_finished_in;
			ADDR_PP_VEL:      accept = vel_ok;
			ADDR_PV_TARGET:   accept = pv_ok;
			ADDR_ABS_TARGET:  accept = abs_in_limits;
			// From standstill the limits may be overrun; position is zeroed first
			ADDR_REL_MOTOR:   accept = motion_finished_in | relm_in_limits;
			ADDR_REL_TARGET:  accept = motion_finished_in | relt_in_limits;
			ADDR_PACKED_RAMP: accept = pack_ok;
			default:          mapped = 1'b0;
		endcase
	end

	// One write qualifier shared by every settings process
	logic do_wr;
	assign do_wr = wr & mapped & accept;

	// Truncating division; an oversized half reads all ones
	// Saturated packed readback halves
	function automatic logic [15:0] sat_half(input logic [31:0] v);
		logic [31:0] q;
		q = v / PACK_SCALE;
		sat_half = (q[31:16] != 16'h0000) ? HALF_SAT : q[15:0];
	endfunction

	// Unmapped reads return zero beside the error flag
	// Read multiplexer
	logic [31:0] rd_value;
	always_comb begin
		rd_value = 32'h0000_0000;
		case (req_in.addr)
			ADDR_SCALE_DEN:   rd_value = scale_denominator;
			ADDR_SCALE_NUM:   rd_value = scale_numerator;
			ADDR_PROF_ACC:    rd_value = profile_acceleration;
			ADDR_PROF_DEC:    rd_value = profile_deceleration;
			ADDR_ROT_DIR:     rd_value = {31'h0, rotation_direction};
			ADDR_JERK:        rd_value = {24'h0, jerk_filter_time};
			ADDR_PP_VEL:      rd_value = {16'h0, position_mode_target_velocity};
			ADDR_PV_TARGET:   rd_value = velocity_mode_target;
			ADDR_ABS_TARGET:  rd_value = absolute_target_position;
			ADDR_REL_MOTOR:   rd_value = relative_to_motor_target;
			ADDR_REL_TARGET:  rd_value = relative_to_target_target;
			ADDR_PACKED_RAMP: rd_value = {sat_half(profile_acceleration), sat_half(profile_deceleration)};
			default:          rd_value = 32'h0000_0000;
		endcase
	end

	// Refused requests are answered too, so the master never
	// waits more than one cycle for any reply
	// Answer: one cycle after every request
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rsp_out <= '0;
		end else begin
			rsp_out.ack   <= req_valid_in;
			rsp_out.err   <= req_valid_in & (~mapped | (req_in.write & ~accept));
			rsp_out.rdata <= (rd & mapped) ? rd_value : 32'h0000_0000;
		end
	end

	// Master reads the pending value; the output keeps its sense
	// until power-on so a turning shaft never reverses
	// Direction: stored now, in force only after the next power-on
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rotation_direction   <= RST_ROT_DIR;
			active_direction_out <= RST_ROT_DIR;
		end else begin
			if (do_wr && req_in.addr == ADDR_ROT_DIR) begin
				rotation_direction <= wv[0];
			end
			// Power-on takes whatever is pending at that edge
			if (power_on_in) begin
				active_direction_out <= rotation_direction;
			end
		end
	end

	// Both active values move on one edge, so no stale pairing
	// Scaling: denominator is staged until the numerator is written
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			scale_denominator    <= RST_SCALE_DEN;
			scale_numerator      <= RST_SCALE_NUM;
			active_scale_den_out <= RST_SCALE_DEN;
			active_scale_num_out <= RST_SCALE_NUM;
		end else if (do_wr) begin
			if (req_in.addr == ADDR_SCALE_DEN) begin
				scale_denominator <= wv;
			end
			// Numerator write commits the staged denominator
			if (req_in.addr == ADDR_SCALE_NUM) begin
				scale_numerator      <= wv;
				active_scale_num_out <= wv;
				active_scale_den_out <= scale_denominator;
			end
		end
	end

	// Packed word has no storage; it writes through to both ramps
	// and a refused packed write leaves both as they were
	// Ramps and jerk: ramps change freely, jerk only with motion finished; motion copies latch at start
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			profile_acceleration <= RST_PROF_ACC;
			profile_deceleration <= RST_PROF_DEC;
			jerk_filter_time     <= RST_JERK;
		end else if (do_wr) begin
			case (req_in.addr)
				ADDR_PROF_ACC: begin
					profile_acceleration <= wv;
				end
				ADDR_PROF_DEC: begin
					profile_deceleration <= wv;
				end
				// Both halves land on the same edge
				ADDR_PACKED_RAMP: begin
					profile_acceleration <= pack_acc;
					profile_deceleration <= pack_dec;
				end
				// Accepted only with the motion finished
				ADDR_JERK: begin
					jerk_filter_time <= wv[7:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Three extra registers buy a motion no ramp write bends
	// Motion copies; a write in the start cycle is not yet seen by that motion
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			active_acc_out  <= RST_PROF_ACC;
			active_dec_out  <= RST_PROF_DEC;
			active_jerk_out <= RST_JERK;
		end else if (motion_start_in) begin
			active_acc_out  <= profile_acceleration;
			active_dec_out  <= profile_deceleration;
			active_jerk_out <= jerk_filter_time;
		end
	end

	// Raw requests kept so a raised maximum lifts the clamp
	// Velocity requests
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			position_mode_target_velocity <= RST_PP_VEL;
			velocity_mode_target          <= RST_PV_TARGET;
		end else if (do_wr) begin
			if (req_in.addr == ADDR_PP_VEL) begin
				position_mode_target_velocity <= wv[15:0];
			end
			// Applies at once; the clamp follows next cycle
			if (req_in.addr == ADDR_PV_TARGET) begin
				velocity_mode_target <= wv;
			end
		end
	end

	// Clamping to the smaller of the two maxima, tracked every cycle
	// Caps come from pins and may change in any cycle
	// Clamped outputs lag the stored request by one cycle
	logic [15:0] vel_cap;
	logic [31:0] pv_req_mag;
	logic [31:0] pv_clamped_mag;
	assign vel_cap        = (max_profile_velocity_in < max_speed_in) ? max_profile_velocity_in : max_speed_in;
	assign pv_req_mag     = velocity_mode_target[31] ? (32'h0000_0000 - velocity_mode_target) : velocity_mode_target;
	assign pv_clamped_mag = (pv_req_mag > {16'h0000, vel_cap}) ? {16'h0000, vel_cap} : pv_req_mag;

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pp_velocity_out <= 16'h0000;
			pv_velocity_out <= 32'h0000_0000;
		end else begin
			pp_velocity_out <= (position_mode_target_velocity > vel_cap) ? vel_cap
			                   : position_mode_target_velocity;
			pv_velocity_out <= velocity_mode_target[31] ? (32'h0000_0000 - pv_clamped_mag)
			                   : pv_clamped_mag;
		end
	end

	// Relative forms sum in the write cycle; while moving, a sum
	// that wraps 32 bits fails the limit check and is refused
	// Position holds between strobes for the controller to read
	// Target positions: a new target issues immediately
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			absolute_target_position  <= RST_POSITION;
			relative_to_motor_target  <= RST_POSITION;
			relative_to_target_target <= RST_POSITION;
			current_target            <= RST_POSITION;
			target_out                <= '0;
		end else begin
			// Strobes drop unless an accepted write raises them
			target_out.valid    <= 1'b0;
			target_out.zero_pos <= 1'b0;
			if (do_wr) begin
				case (req_in.addr)
					// Absolute form replaces the running target
					ADDR_ABS_TARGET: begin
						absolute_target_position <= wv;
						current_target           <= wv;
						target_out.valid         <= 1'b1;
						target_out.position      <= wv;
					end
					// Motor form refers to the actual position
					ADDR_REL_MOTOR: begin
						relative_to_motor_target <= wv;
						target_out.valid         <= 1'b1;
						if (motion_finished_in) begin
							// Position is zeroed, so the offset becomes the target
							current_target      <= wv;
							target_out.position <= wv;
							target_out.zero_pos <= 1'b1;
						end else begin
							current_target      <= rel_motor_sum[31:0];
							target_out.position <= rel_motor_sum[31:0];
						end
					end
					// Target form refers to the running target
					ADDR_REL_TARGET: begin
						relative_to_target_target <= wv;
						target_out.valid          <= 1'b1;
						if (motion_finished_in) begin
							current_target      <= wv;
							target_out.position <= wv;
							target_out.zero_pos <= 1'b1;
						end else begin
							current_target      <= rel_target_sum[31:0];
							target_out.position <= rel_target_sum[31:0];
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

endmodule

//--- mpb_pkg.sv
// Package of constants and carriers for the motion profile parameter bank
package mpb_pkg;

	// Parameter addresses of the drive's parameter access port
	localparam logic [15:0] ADDR_SCALE_DEN    = 16'h060E; // Scaling denominator
	localparam logic [15:0] ADDR_SCALE_NUM    = 16'h0610; // Scaling numerator
	localparam logic [15:0] ADDR_PROF_ACC     = 16'h0614; // Acceleration
	localparam logic [15:0] ADDR_PROF_DEC     = 16'h0616; // Deceleration
	localparam logic [15:0] ADDR_ROT_DIR      = 16'h0618; // Rotation direction
	localparam logic [15:0] ADDR_JERK         = 16'h061A; // Jerk filter time
	localparam logic [15:0] ADDR_PP_VEL       = 16'h0600; // Profile position target velocity
	localparam logic [15:0] ADDR_ABS_TARGET   = 16'h0602; // Absolute target position
	localparam logic [15:0] ADDR_REL_MOTOR    = 16'h0604; // Relative to motor position
	localparam logic [15:0] ADDR_REL_TARGET   = 16'h0606; // Relative to current target
	localparam logic [15:0] ADDR_PV_TARGET    = 16'h0608; // Profile velocity target
	localparam logic [15:0] ADDR_PACKED_RAMP  = 16'h060A; // Packed acceleration/deceleration

	// Reset (factory) values
	localparam logic [31:0] RST_SCALE_DEN     = 32'h0000_4000;
	localparam logic [31:0] RST_SCALE_NUM     = 32'h0000_0001;
	localparam logic [31:0] RST_PROF_ACC      = 32'h0000_0258;
	localparam logic [31:0] RST_PROF_DEC      = 32'h0000_02EE;
	localparam logic        RST_ROT_DIR       = 1'h0;
	localparam logic [7:0]  RST_JERK          = 8'h00;
	localparam logic [15:0] RST_PP_VEL        = 16'h003C;
	localparam logic [31:0] RST_POSITION      = 32'h0000_0000;
	localparam logic [31:0] RST_PV_TARGET     = 32'h0000_0000;

	// Limits
	localparam logic [31:0] SCALE_MIN         = 32'h0000_0001;
	localparam logic [31:0] SCALE_MAX         = 32'h7FFF_FFFF;
	localparam logic [15:0] VEL_MIN           = 16'h0001;
	localparam logic [15:0] VEL_MAX           = 16'h3390;   // 13200 RPM
	localparam logic [31:0] ACC_MIN           = 32'h0000_0001;
	localparam logic [31:0] DEC_MIN           = 32'h0000_02EE; // 750 RPM/s
	localparam logic [31:0] RAMP_MAX          = 32'h002D_C6C0; // 3000000 RPM/s
	localparam logic [31:0] PACK_SCALE        = 32'h0000_000A; // Packed halves count 10 RPM/s
	localparam logic [15:0] HALF_SAT          = 16'hFFFF;
	localparam logic [15:0] JERK_ALLOWED_MASK = 16'h00FF;   // Bit k set: 2**k ms; all clear is off

	// Rotation direction encodings
	localparam logic        DIR_CW            = 1'h0;
	localparam logic        DIR_CCW           = 1'h1;

	// Field positions of the packed ramp word
	localparam int          PACK_ACC_LSB      = 16;
	localparam int          PACK_DEC_LSB      = 0;

	// Request from the fieldbus master
	typedef struct packed {
		logic        write;  // 1 write, 0 read
		logic [15:0] addr;   // Parameter address
		logic [31:0] wdata;  // Write value
	} mpb_req_t;

	// Answer to the fieldbus master
	typedef struct packed {
		logic        ack;    // One-cycle answer strobe
		logic        err;    // Rejected or unmapped
		logic [31:0] rdata;  // Read value
	} mpb_rsp_t;

	// Target position event towards the position controller
	typedef struct packed {
		logic        valid;     // One-cycle new target
		logic        zero_pos;  // Set actual position to zero first
		logic [31:0] position;  // Target in user units
	} mpb_target_t;

endpackage

//--- mpb_master_model.sv
// Fieldbus master model that issues parameter requests to the bank
`timescale 1ns/1ps
module mpb_master_model
	import mpb_pkg::*;
(
	input  wire logic      ref_clk_in,    // Drive clock
	input  wire mpb_rsp_t  rsp_in,        // Answer from the bank
	output logic           req_valid_out, // One-cycle request strobe
	output mpb_req_t       req_out        // Request fields
);
	// Idle bus at time zero
	initial begin
		req_valid_out = 1'b0;
		req_out = '0;
	end
	// One transfer; the answer is taken while its ack stands
	task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
		output logic e, output logic [31:0] q);
		@(negedge ref_clk_in);
		req_valid_out = 1'b1;
		req_out = '{w, a, d};
		@(negedge ref_clk_in);
		req_valid_out = 1'b0;
		// Released fields flip so a stale value cannot pass for a live one
		req_out = ~req_out;
		// A missing ack makes the answer unknown so the compare fails
		e = rsp_in.ack ? rsp_in.err : 1'bx;
		q = rsp_in.ack ? rsp_in.rdata : 32'hXXXX_XXXX;
	endtask
endmodule

//--- mpb_param_bank_assertions.sv
// Concurrent checks on the parameter bank ports
`timescale 1ns/1ps
module mpb_param_bank_checker
	import mpb_pkg::*;
(
	input wire logic        ref_clk_in,
	input wire logic        nrst_in,
	input wire logic        req_valid_in,
	input wire mpb_req_t    req_in,
	input wire logic        power_stage_en_in,
	input wire logic        power_on_in,
	input wire logic        motion_finished_in,
	input wire logic        motion_start_in,
	input wire logic [31:0] motor_position_in,
	input wire mpb_rsp_t    rsp_out,
	input wire mpb_target_t target_out,
	input wire logic        active_direction_out,
	input wire logic [31:0] active_scale_den_out,
	input wire logic [31:0] active_scale_num_out,
	input wire logic [31:0] active_acc_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!nrst_in);
	// Write strobes decoded per address
	wire logic wr_num = req_valid_in && req_in.write && req_in.addr == ADDR_SCALE_NUM;
	wire logic wr_abs = req_valid_in && req_in.write && req_in.addr == ADDR_ABS_TARGET;
	wire logic wr_relm = req_valid_in && req_in.write && req_in.addr == ADDR_REL_MOTOR;
	wire logic wr_jerk = req_valid_in && req_in.write && req_in.addr == ADDR_JERK;
	sequence s_req_ack;
		req_valid_in ##1 rsp_out.ack;
	endsequence
	sequence s_idle_quiet;
		!req_valid_in ##1 !rsp_out.ack;
	endsequence
	a_ack_follows_req: assert property (req_valid_in |-> s_req_ack) else $error("ack missing");
	a_ack_not_spurious: assert property (!req_valid_in |-> s_idle_quiet) else $error("ack without request");
	a_den_waits_num: assert property ($changed(active_scale_den_out) |-> $past(wr_num))
		else $error("den early");
	a_scale_locked: assert property (
		wr_num && power_stage_en_in |=> rsp_out.err && $stable(active_scale_num_out))
		else $error("scale write taken while enabled");
	a_dir_power_on: assert property ($changed(active_direction_out) |-> $past(power_on_in))
		else $error("direction changed without power-on");
	a_ramp_held_run: assert property (!motion_start_in |=> $stable(active_acc_out))
		else $error("ramp changed");
	a_jerk_locked: assert property (wr_jerk && !motion_finished_in |=> rsp_out.err)
		else $error("jerk taken");
	a_abs_immediate: assert property (
		wr_abs |=> rsp_out.err || target_out.valid && target_out.position == $past(req_in.wdata))
		else $error("abs target wrong");
	a_rel_motor_sum: assert property (
		wr_relm && !motion_finished_in |=> rsp_out.err ||
		target_out.position == $past(motor_position_in) + $past(req_in.wdata)) else $error("relative sum wrong");
	a_rel_zero_pos: assert property (
		wr_relm && motion_finished_in |=> target_out.valid && target_out.zero_pos)
		else $error("standstill move not zeroed");
endmodule
bind mpb_param_bank mpb_param_bank_checker mpb_param_bank_checker_inst (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
	.req_valid_in(req_valid_in), .req_in(req_in), .power_stage_en_in(power_stage_en_in), .power_on_in(power_on_in),
	.motion_finished_in(motion_finished_in), .motion_start_in(motion_start_in), .motor_position_in(motor_position_in),
	.rsp_out(rsp_out), .target_out(target_out), .active_direction_out(active_direction_out),
	.active_scale_den_out(active_scale_den_out), .active_scale_num_out(active_scale_num_out),
	.active_acc_out(active_acc_out));

//--- testbench.sv
// Self-checking testbench of the parameter bank
`timescale 1ns/1ps
module testbench;
	import mpb_pkg::*;
	logic clk, nrst, rv, pse, pon, fin, mst, e;
	logic [31:0] mpos, lmin, lmax, q;
	logic [15:0] mpv, msp;
	mpb_req_t req;
	mpb_rsp_t rsp;
	mpb_target_t tgt;
	logic dir;
	logic [31:0] num, den, acc, dec, pv;
	logic [7:0] jrk;
	logic [15:0] pp;
	int n_errors = 0, check_count = 0, cyc = 0;
	mpb_param_bank mpb_param_bank_inst (.ref_clk_in(clk), .nrst_in(nrst), .req_valid_in(rv), .req_in(req),
		.power_stage_en_in(pse), .power_on_in(pon), .motion_finished_in(fin), .motion_start_in(mst),
		.motor_position_in(mpos), .pos_limit_min_in(lmin), .pos_limit_max_in(lmax), .max_profile_velocity_in(mpv),
		.max_speed_in(msp), .rsp_out(rsp), .target_out(tgt), .active_direction_out(dir), .active_scale_num_out(num),
		.active_scale_den_out(den), .active_acc_out(acc), .active_dec_out(dec), .active_jerk_out(jrk),
		.pp_velocity_out(pp), .pv_velocity_out(pv));
	mpb_master_model mpb_master_model_inst (.ref_clk_in(clk), .rsp_in(rsp), .req_valid_out(rv), .req_out(req));
	// Clock at 8 ns; the timeout cuts a hang short
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		if (n_errors == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		check_count++;
		if (s !== x) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic xe);
		mpb_master_model_inst.xfer(1'b1, a, d, e, q);
		chk("write err", {31'h0, e}, {31'h0, xe});
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] x);
		mpb_master_model_inst.xfer(1'b0, a, 32'h0, e, q);
		chk("read data", q, x);
	endtask
	// Single-cycle strobe on a control input
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask
	localparam logic [15:0] DA [7] = '{ADDR_SCALE_DEN, ADDR_SCALE_NUM, ADDR_PROF_ACC, ADDR_PROF_DEC, ADDR_ROT_DIR,
		ADDR_JERK, ADDR_PP_VEL};
	localparam logic [31:0] DV [7] = '{32'h4000, 32'h1, 32'h258, 32'h2EE, 32'h0, 32'h0, 32'h3C};
	initial begin
		{nrst, pse, pon, fin, mst} = 5'h02;
		{mpos, lmin, lmax} = {32'h64, 32'hFFFFFC18, 32'h3E8};
		{mpv, msp} = {16'hBB8, 16'h3390};
		repeat (6) @(negedge clk);
		nrst = 1'b1;
		// Factory values, then an unmapped place
		for (int i = 0; i < 7; i++) rd(DA[i], DV[i]);
		wr(16'h0700, 32'h1, 1'b1);
		// Scaling and direction locked while enabled, then denominator staged until numerator
		pse = 1'b1;
		wr(ADDR_SCALE_DEN, 32'h64, 1'b1);
		wr(ADDR_SCALE_NUM, 32'h5, 1'b1);
		wr(ADDR_ROT_DIR, 32'h1, 1'b1);
		chk("num locked", num, 32'h1);
		pse = 1'b0;
		wr(ADDR_SCALE_DEN, 32'h0, 1'b1);
		wr(ADDR_SCALE_DEN, 32'h64, 1'b0);
		chk("den held", den, 32'h4000);
		wr(ADDR_SCALE_NUM, 32'h3, 1'b0);
		chk("den live", den, 32'h64);
		chk("num live", num, 32'h3);
		// Direction waits for power-on
		wr(ADDR_ROT_DIR, 32'h2, 1'b1);
		wr(ADDR_ROT_DIR, 32'h1, 1'b0);
		chk("dir held", {31'h0, dir}, 32'h0);
		pulse(pon);
		chk("dir ccw", {31'h0, dir}, 32'h1);
		// Ramps and jerk wait for motion start
		wr(ADDR_PROF_ACC, 32'h3E8, 1'b0);
		chk("acc held", acc, 32'h258);
		for (int i = 0; i < 9; i++) wr(ADDR_JERK, (i == 0) ? 32'h0 : (32'h1 << (i - 1)), 1'b0);
		wr(ADDR_JERK, 32'h3, 1'b1);
		wr(ADDR_JERK, 32'h100, 1'b1);
		fin = 1'b0;
		wr(ADDR_JERK, 32'h4, 1'b1);
		pulse(mst);
		chk("acc run", acc, 32'h3E8);
		chk("jerk run", {24'h0, jrk}, 32'h80);
		// Packed ramp word
		wr(ADDR_PACKED_RAMP, {16'h5, 16'h50}, 1'b0);
		rd(ADDR_PROF_ACC, 32'h32);
		rd(ADDR_PROF_DEC, 32'h320);
		wr(ADDR_PACKED_RAMP, {16'h5, 16'h46}, 1'b1);
		rd(ADDR_PROF_DEC, 32'h320);
		wr(ADDR_PROF_ACC, 32'h2DC6C0, 1'b0);
		rd(ADDR_PACKED_RAMP, {16'hFFFF, 16'h50});
		pulse(mst);
		chk("dec run", dec, 32'h320);
		// Targets while moving, then from standstill
		wr(ADDR_ABS_TARGET, 32'h7D0, 1'b1);
		wr(ADDR_ABS_TARGET, 32'h1F4, 1'b0);
		chk("abs", tgt.position, 32'h1F4);
		wr(ADDR_REL_MOTOR, 32'h32, 1'b0);
		chk("rel motor", tgt.position, 32'h96);
		wr(ADDR_REL_TARGET, 32'h14, 1'b0);
		chk("rel target", tgt.position, 32'hAA);
		fin = 1'b1;
		wr(ADDR_REL_TARGET, 32'h1388, 1'b0);
		chk("zero pos", {31'h0, tgt.zero_pos}, 32'h1);
		chk("zero target", tgt.position, 32'h1388);
		wr(ADDR_REL_MOTOR, 32'h1770, 1'b0);
		chk("zero pos motor", {31'h0, tgt.zero_pos}, 32'h1);
		chk("zero motor", tgt.position, 32'h1770);
		// Velocity target range check, then position velocity clamped to the maxima
		wr(ADDR_PV_TARGET, 32'hFFFFB1E0, 1'b1);
		wr(ADDR_PV_TARGET, 32'hFFFFFF38, 1'b0);
		wr(ADDR_PP_VEL, 32'h1388, 1'b0);
		@(negedge clk);
		chk("pv", pv, 32'hFFFFFF38);
		chk("pp clamp", {16'h0, pp}, 32'hBB8);
		wrap_up();
	end
endmodule
